// file: shared/die_link_pkg.sv
// constants and types shared by the die link initiator control block
package die_link_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_PRI = 8'hd8;
  localparam logic [7:0] IDX_CTRL_SEC = 8'hd9;
  localparam logic [7:0] IDX_ERR_STAT = 8'hda;
  localparam logic [7:0] IDX_IRQ_BUSY = 8'hdb;
  localparam logic [7:0] IDX_LAST_ATTR = 8'hdc;
  localparam logic [7:0] IDX_LAST_ADDR = 8'hdd;
  localparam logic [7:0] IDX_DATA_HI = 8'hde;
  localparam logic [7:0] IDX_DATA_LO = 8'hdf;
  localparam logic [7:0] IDX_EVT_STAT = 8'he0;
  localparam logic [7:0] IDX_EVT_EN = 8'he1;
  localparam logic [7:0] IDX_EVT_CLR = 8'he2;
  // paddr[11:10] selects registers, blocking window or non-blocking window
  localparam logic [1:0] SEL_REGS = 2'h0;
  localparam logic [1:0] SEL_WIN_BLK = 2'h2;
  localparam logic [1:0] SEL_WIN_NB = 2'h3;
  // field positions
  localparam int EN_BIT = 7;
  localparam int CW_BIT = 6;
  localparam int HALT_BIT = 5;
  localparam int DIV_LSB = 0;
  localparam int IE_BIT = 7;
  localparam int TMO_LSB = 0;
  localparam int ERR_SUM_BIT = 7;
  localparam int IF_BIT = 7;
  localparam int BSY_BIT = 6;
  localparam int RWB_BIT = 7;
  localparam int SZ8_BIT = 6;
  localparam int NONBLOCKING_MARKER_BIT = 4;
  localparam int EVT_ERR = 0;
  localparam int EVT_TIRQ = 1;
  localparam int EVT_DONE = 2;
  // reset values
  localparam logic [7:0] CTRL_PRI_RST = 8'h00;
  localparam logic [7:0] CTRL_SEC_RST = 8'h00;
  localparam logic [2:0] EVT_RST = 3'h0;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } win_state_t;
endpackage

// file: src/die_link_initiator_control.sv
// die link initiator: apb registers, clock divider, pin control, error flags
`timescale 1ns/10ps
module die_link_initiator_control
  import die_link_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  input wire logic wait_mode,
  input wire logic stop_mode,
  output logic link_clock_out,
  output logic link_clock_oe,
  output logic [7:0] link_data_out,
  output logic [7:0] link_data_oe,
  input wire logic target_irq_input,
  output logic target_irq_out,
  output logic error_irq_out,
  output logic irq,
  output logic txn_req,
  output logic txn_write,
  output logic txn_nonblocking,
  output logic txn_byte,
  output logic [7:0] txn_addr,
  output logic [15:0] txn_wdata,
  input wire logic [15:0] txn_rdata,
  input wire logic txn_done,
  input wire logic ack_wait,
  input wire logic ack_fault_evt,
  input wire logic cancel_evt,
  input wire logic target_err_evt,
  input wire logic parity_err_evt,
  input wire logic [1:0] parity_bits
);
  logic link_enable_bit_reg;
  logic connection_width_select_reg;
  logic halt_clock_in_wait_reg;
  logic [1:0] link_clock_divider_reg;
  logic target_irq_enable_reg;
  logic [3:0] timeout_reg;
  logic [7:0] err_stat_reg;
  logic busy_reg;
  logic [7:0] last_attr_reg;
  logic [7:0] last_addr_reg;
  logic [15:0] last_data_reg;
  logic [2:0] evt_stat_reg;
  logic [2:0] evt_en_reg;
  logic [1:0] div_cnt_reg;
  logic running_reg;
  logic clk_reg;
  logic [3:0] wait_cnt_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic tirq_lvl_reg;
  logic tirq_prev_reg;
  win_state_t state_reg;

  logic [1:0] sel;
  logic [7:0] idx;
  logic reg_hit;
  logic win_hit;
  logic wr_acc;
  logic rd_acc;
  logic locked;
  logic issue;
  logic run_req;
  logic period_end;
  logic tick;
  logic [1:0] cnt_next;
  logic running_next;
  logic [2:0] high_cycles;
  logic timeout_evt;
  logic err_any;
  logic err_clr;
  logic [2:0] evt_set;
  logic [7:0] rd_byte;

  // address decode: register block and the two 256-entry windows
  assign sel = paddr[11:10];
  assign idx = paddr[9:2];
  assign win_hit = (sel == SEL_WIN_BLK) || (sel == SEL_WIN_NB);
  assign reg_hit = (sel == SEL_REGS) && (idx >= IDX_CTRL_PRI) && (idx <= IDX_EVT_CLR);
  assign wr_acc = psel && penable && pwrite && reg_hit;
  assign rd_acc = psel && penable && !pwrite && reg_hit;

  // write-once fields lock while enabled outside special mode
  assign locked = link_enable_bit_reg && !special_mode;

  // primary control; halt bit is always writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_enable_bit_reg <= CTRL_PRI_RST[EN_BIT];
      connection_width_select_reg <= CTRL_PRI_RST[CW_BIT];
      halt_clock_in_wait_reg <= CTRL_PRI_RST[HALT_BIT];
      link_clock_divider_reg <= CTRL_PRI_RST[DIV_LSB +: 2];
    end else if (wr_acc && idx == IDX_CTRL_PRI && pstrb[0]) begin
      halt_clock_in_wait_reg <= pwdata[HALT_BIT];
      if (!locked) begin
        link_enable_bit_reg <= pwdata[EN_BIT];
        connection_width_select_reg <= pwdata[CW_BIT];
        link_clock_divider_reg <= pwdata[DIV_LSB +: 2];
      end
    end
  end

  // secondary control; timeout is write-once as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_irq_enable_reg <= CTRL_SEC_RST[IE_BIT];
      timeout_reg <= CTRL_SEC_RST[TMO_LSB +: 4];
    end else if (wr_acc && idx == IDX_CTRL_SEC && pstrb[0]) begin
      target_irq_enable_reg <= pwdata[IE_BIT];
      if (!locked) begin
        timeout_reg <= pwdata[TMO_LSB +: 4];
      end
    end
  end

  // clock divider: high for floor(n/2) cycles, so odd ratios run short high
  assign high_cycles = ({1'b0, link_clock_divider_reg} + 3'd1) >> 1;
  assign run_req = link_enable_bit_reg && !stop_mode && !(wait_mode && halt_clock_in_wait_reg);
  assign period_end = (div_cnt_reg == link_clock_divider_reg);
  assign tick = running_reg && period_end;
  // a stop is only taken at a period end, after the high phase is over
  assign running_next = running_reg ? (period_end ? run_req : 1'b1) : run_req;
  assign cnt_next = (!running_next || !running_reg || period_end) ? 2'd0 : div_cnt_reg + 2'd1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_reg <= 1'b0;
      div_cnt_reg <= 2'd0;
      clk_reg <= 1'b0;
    end else begin
      running_reg <= running_next;
      div_cnt_reg <= cnt_next;
      clk_reg <= running_next && ({1'b0, cnt_next} < high_cycles);
    end
  end

  // divide by one: high half of the bus clock would break the high-phase
  // limit on restart, so the low half is used and gated by the running flag
  assign link_clock_out = (link_clock_divider_reg == 2'd0) ? (running_reg && !pclk) : clk_reg;
  assign link_clock_oe = link_enable_bit_reg;
  // idle command is all lines low; the protocol engine lives elsewhere
  assign link_data_out = 8'h00;
  assign link_data_oe = link_enable_bit_reg ? {{4{connection_width_select_reg}}, 4'hf} : 8'h00;

  // target interrupt pin: three stages, level taken when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      tirq_lvl_reg <= 1'b0;
      tirq_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= target_irq_input;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        tirq_lvl_reg <= sync3_reg && link_enable_bit_reg;
      end
      tirq_prev_reg <= tirq_lvl_reg;
    end
  end
  assign target_irq_out = tirq_lvl_reg && target_irq_enable_reg;

  // ack timeout: count link periods of target wait, flag past the setting
  assign timeout_evt = ack_wait && tick && (wait_cnt_reg >= timeout_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_reg <= 4'h0;
    end else if (!ack_wait) begin
      wait_cnt_reg <= 4'h0;
    end else if (tick && wait_cnt_reg != 4'hf) begin
      wait_cnt_reg <= wait_cnt_reg + 4'h1;
    end
  end

  // error flags: a new event wins over a simultaneous clear
  assign err_any = ack_fault_evt || cancel_evt || timeout_evt || target_err_evt || parity_err_evt;
  assign err_clr = wr_acc && idx == IDX_ERR_STAT && pstrb[0] && pwdata[ERR_SUM_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_stat_reg <= 8'h00;
    end else begin
      err_stat_reg <= (err_clr ? 8'h00 : err_stat_reg) | {
        err_any, ack_fault_evt, cancel_evt, timeout_evt, target_err_evt, parity_err_evt,
        parity_err_evt ? parity_bits : 2'b00};
    end
  end
  assign error_irq_out = err_stat_reg[ERR_SUM_BIT];

  // window access: blocking stalls until done, non-blocking write completes at issue
  assign issue = psel && penable && win_hit && link_enable_bit_reg && !busy_reg
    && state_reg == ST_IDLE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      txn_req <= 1'b0;
      txn_write <= 1'b0;
      txn_nonblocking <= 1'b0;
      txn_byte <= 1'b0;
      txn_addr <= 8'h00;
      txn_wdata <= 16'h0000;
      last_attr_reg <= 8'h00;
      last_addr_reg <= 8'h00;
      last_data_reg <= 16'h0000;
    end else begin
      txn_req <= issue;
      if (issue) begin
        busy_reg <= 1'b1;
        txn_write <= pwrite;
        txn_nonblocking <= (sel == SEL_WIN_NB) && pwrite;
        txn_byte <= pwrite && !pstrb[1];
        txn_addr <= idx;
        txn_wdata <= pwdata[15:0];
        last_attr_reg <= 8'h00;
        last_attr_reg[RWB_BIT] <= !pwrite;
        last_attr_reg[SZ8_BIT] <= pwrite && !pstrb[1];
        last_attr_reg[NONBLOCKING_MARKER_BIT] <= (sel == SEL_WIN_NB) && pwrite;
        last_addr_reg <= idx;
        if (pwrite) begin
          last_data_reg <= pwdata[15:0];
        end
        if (!((sel == SEL_WIN_NB) && pwrite)) begin
          state_reg <= ST_WAIT;
        end
      end else if (txn_done) begin
        busy_reg <= 1'b0;
        if (!txn_write) begin
          last_data_reg <= txn_rdata;
        end
        state_reg <= ST_IDLE;
      end
    end
  end

  // interrupt events: sticky, set wins over clear
  assign evt_set = {txn_done && busy_reg, tirq_lvl_reg && !tirq_prev_reg, err_any};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat_reg <= EVT_RST;
      evt_en_reg <= EVT_RST;
    end else begin
      if (wr_acc && idx == IDX_EVT_CLR && pstrb[0]) begin
        evt_stat_reg <= (evt_stat_reg & ~pwdata[2:0]) | evt_set;
      end else begin
        evt_stat_reg <= evt_stat_reg | evt_set;
      end
      if (wr_acc && idx == IDX_EVT_EN && pstrb[0]) begin
        evt_en_reg <= pwdata[2:0];
      end
    end
  end
  assign irq = |(evt_stat_reg & evt_en_reg);

  // read mux; reserved bits read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_CTRL_PRI: rd_byte = {link_enable_bit_reg, connection_width_select_reg,
        halt_clock_in_wait_reg, 3'b000, link_clock_divider_reg};
      IDX_CTRL_SEC: rd_byte = {target_irq_enable_reg, 3'b000, timeout_reg};
      IDX_ERR_STAT: rd_byte = err_stat_reg;
      IDX_IRQ_BUSY: rd_byte = {tirq_lvl_reg, busy_reg, 6'h00};
      IDX_LAST_ATTR: rd_byte = last_attr_reg;
      IDX_LAST_ADDR: rd_byte = last_addr_reg;
      IDX_DATA_HI: rd_byte = last_data_reg[15:8];
      IDX_DATA_LO: rd_byte = last_data_reg[7:0];
      IDX_EVT_STAT: rd_byte = {5'h00, evt_stat_reg};
      IDX_EVT_EN: rd_byte = {5'h00, evt_en_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  // apb answer: registers, refused accesses and non-blocking window writes to an idle engine in one cycle, other enabled window accesses wait on the engine
  always_comb begin
    prdata = 32'h0000_0000;
    pready = 1'b1;
    pslverr = 1'b0;
    if (psel && penable) begin
      if (reg_hit) begin
        prdata = rd_acc ? {24'h000000, rd_byte} : 32'h0000_0000;
      end else if (win_hit && link_enable_bit_reg) begin
        pready = (issue && sel == SEL_WIN_NB && pwrite) || (state_reg == ST_WAIT && txn_done);
        prdata = {16'h0000, txn_rdata};
      end else begin
        pslverr = 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence halt_held;
    !run_req [*5];
  endsequence

  // a divider rewrite in special mode does not restart the count, so one period can run odd; only steady spans are judged
  sequence div3_steady;
    (link_clock_divider_reg == 2'd2) [*3];
  endsequence

  pins_released_a: assert property (!link_enable_bit_reg |-> link_data_oe == 8'h00
    && !link_clock_oe) else $error("link pins driven while disabled");
  idle_lines_a: assert property (link_enable_bit_reg |-> link_data_out == 8'h00
    && link_data_oe[3:0] == 4'hf) else $error("idle lines not driven low");
  lock_hold_a: assert property (locked && wr_acc && idx == IDX_CTRL_PRI |=>
    $stable(link_clock_divider_reg) && $stable(connection_width_select_reg))
    else $error("locked field changed");
  narrow_width_a: assert property (!connection_width_select_reg |->
    link_data_oe[7:4] == 4'h0) else $error("upper lines driven in narrow mode");
  clock_halted_a: assert property (halt_held |-> !running_reg && !clk_reg)
    else $error("link clock still running");
  div3_period_a: assert property (tick && run_req && link_clock_divider_reg == 2'd2
    ##1 div3_steady |-> tick && !$past(tick) && !$past(tick, 2))
    else $error("divide by three period wrong");
  short_high_a: assert property ($rose(clk_reg) |-> ##[1:2] !clk_reg)
    else $error("link clock high too long");
  div2_high_a: assert property ($rose(clk_reg) && link_clock_divider_reg != 2'd3
    |=> !clk_reg) else $error("odd ratio high phase too long");
  timeout_flag_a: assert property (ack_wait && tick && wait_cnt_reg >= timeout_reg
    |=> err_stat_reg[4] && err_stat_reg[ERR_SUM_BIT]) else $error("timeout not flagged");
  err_clear_a: assert property (err_clr && !err_any |=> err_stat_reg == 8'h00)
    else $error("error flags not cleared");
  irq_gate_a: assert property (!target_irq_enable_reg |-> !target_irq_out)
    else $error("target interrupt forwarded while gated");
  reserved_zero_a: assert property (rd_acc && idx == IDX_CTRL_PRI |->
    prdata[4:2] == 3'b000) else $error("reserved bits read nonzero");
  unmapped_err_a: assert property (psel && penable && !reg_hit && !win_hit |->
    pslverr && pready) else $error("unmapped access not refused");
endmodule

// file: tb/link_target_model.sv
// behavioural target die engine answering the initiator's transfer requests
`timescale 1ns/10ps
module link_target_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic txn_req,
  input wire logic [7:0] txn_addr,
  input wire logic [7:0] lat,
  output logic txn_done,
  output logic ack_wait,
  output logic [15:0] txn_rdata
);
  logic busy_reg;
  logic [7:0] cnt_reg;
  logic [7:0] addr_reg;
  // data only valid with done; inverted otherwise so a stale value never matches
  assign txn_rdata = txn_done ? {8'hc3, addr_reg} : ~{8'hc3, addr_reg};
  // one done per request, at least a cycle later; lat wait cycles shown on ack_wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      cnt_reg <= 8'h00;
      addr_reg <= 8'h00;
      txn_done <= 1'b0;
      ack_wait <= 1'b0;
    end else begin
      txn_done <= 1'b0;
      if (txn_req) begin
        busy_reg <= 1'b1;
        cnt_reg <= lat;
        addr_reg <= txn_addr;
      end else if (busy_reg) begin
        ack_wait <= (cnt_reg != 8'h00);
        if (cnt_reg == 8'h00) begin
          txn_done <= 1'b1;
          busy_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      end
    end
  end
endmodule

// file: tb/die_link_initiator_control_tb.sv
// register, clock, window and error-flag tests for the die link initiator
`timescale 1ns/10ps
module die_link_initiator_control_tb
  import die_link_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic special_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic target_irq_input = 1'b0;
  logic [3:0] evts = 4'h0;
  logic [7:0] lat = 8'h00;
  logic link_clock_out, link_clock_oe, target_irq_out, error_irq_out, irq;
  logic [7:0] link_data_out, link_data_oe, txn_addr;
  logic txn_req, txn_write, txn_nonblocking, txn_byte, txn_done, ack_wait;
  logic [15:0] txn_wdata, txn_rdata;
  logic [31:0] rd;
  logic se;
  int err_total = 0;
  int num_checks = 0;
  die_link_initiator_control u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .special_mode(special_mode),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .link_clock_out(link_clock_out),
    .link_clock_oe(link_clock_oe), .link_data_out(link_data_out),
    .link_data_oe(link_data_oe), .target_irq_input(target_irq_input),
    .target_irq_out(target_irq_out), .error_irq_out(error_irq_out), .irq(irq),
    .txn_req(txn_req), .txn_write(txn_write), .txn_nonblocking(txn_nonblocking),
    .txn_byte(txn_byte), .txn_addr(txn_addr), .txn_wdata(txn_wdata), .txn_rdata(txn_rdata),
    .txn_done(txn_done), .ack_wait(ack_wait), .ack_fault_evt(evts[0]),
    .cancel_evt(evts[1]), .target_err_evt(evts[2]), .parity_err_evt(evts[3]),
    .parity_bits(2'b10));
  link_target_model u_target (.pclk(pclk), .presetn(presetn), .txn_req(txn_req),
    .txn_addr(txn_addr), .lat(lat), .txn_done(txn_done), .ack_wait(ack_wait),
    .txn_rdata(txn_rdata));
  // 40 MHz bus clock
  always #12.5 pclk = ~pclk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one apb transfer, entered at a rising edge; the request stands until pready is
  // seen high at a rising edge, where read data is taken and the request dropped
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500) err_total++;
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so callers look at outputs the transfer has already settled
    @(posedge pclk);
  endtask
  function automatic logic [11:0] ra(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, ra(idx), {24'h0, d});
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, ra(idx), 32'h0);
    chk(rd, {24'h0, exp}, "register");
  endtask
  // counts high samples at both edges and rising edges over 24 cycles
  task automatic clkchk(input int h, input int r);
    int ch = 0;
    int cr = 0;
    logic p, s;
    repeat (8) @(posedge pclk);
    #1 p = link_clock_out;
    repeat (24) begin
      @(negedge pclk);
      #1 ch += int'(link_clock_out);
      @(posedge pclk);
      #1 s = link_clock_out;
      ch += int'(s);
      if (s && !p) cr++;
      p = s;
    end
    // back on a rising edge so the caller drives inputs on the edge
    @(posedge pclk);
    chk(ch, h, "clock high");
    chk(cr, r, "clock rise");
  endtask
  // pulses each error event in turn; the flag set is checked, its clear only by the next pulse's read
  task automatic evt_loop;
    int b[4] = '{6, 5, 3, 2};
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      evts <= 4'h1 << i;
      @(posedge pclk);
      evts <= 4'h0;
      rchk(IDX_ERR_STAT, 8'h80 | (8'h01 << b[i]) | (i == 3 ? 8'h02 : 8'h00));
      wr(IDX_ERR_STAT, 8'h80);
    end
  endtask
  // watchdog: the run needs well under a thousand cycles, the limit is 8000
  initial begin
    #(25 * 8000);
    err_total++;
    end_sim();
  end
  initial begin
    int hx[4] = '{24, 24, 16, 24};
    int rx[4] = '{0, 12, 8, 6};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(IDX_CTRL_PRI, CTRL_PRI_RST);
    rchk(IDX_CTRL_SEC, CTRL_SEC_RST);
    chk({link_clock_oe, link_data_oe}, 9'h0, "pins released");
    wr(IDX_CTRL_SEC, 8'h83);
    wr(IDX_CTRL_PRI, 8'h21);
    rchk(IDX_CTRL_PRI, 8'h21);
    chk(link_clock_out, 1'b0, "clock off");
    // four-line width kept, as only the low lines are bonded
    wr(IDX_CTRL_PRI, 8'h80);
    rchk(IDX_CTRL_PRI, 8'h80);
    chk({link_clock_oe, link_data_oe, link_data_out}, 17'h10f00, "pins");
    wr(IDX_CTRL_PRI, 8'h03);
    rchk(IDX_CTRL_PRI, 8'h80);
    wr(IDX_CTRL_SEC, 8'h05);
    rchk(IDX_CTRL_SEC, 8'h03);
    wr(IDX_CTRL_PRI, 8'ha0);
    rchk(IDX_CTRL_PRI, 8'ha0);
    wait_mode <= 1'b1;
    clkchk(0, 0);
    wait_mode <= 1'b0;
    stop_mode <= 1'b1;
    clkchk(0, 0);
    stop_mode <= 1'b0;
    wr(IDX_CTRL_PRI, 8'h80);
    wait_mode <= 1'b1;
    clkchk(24, 0);
    wait_mode <= 1'b0;
    special_mode <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CTRL_PRI, 8'h80 | 8'(c));
      rchk(IDX_CTRL_PRI, 8'h80 | 8'(c));
      clkchk(hx[c], rx[c]);
    end
    wr(IDX_CTRL_SEC, 8'h83);
    target_irq_input <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(target_irq_out, 1'b1, "target irq on");
    rchk(IDX_IRQ_BUSY, 8'h80);
    wr(IDX_CTRL_SEC, 8'h03);
    chk(target_irq_out, 1'b0, "target irq masked");
    target_irq_input <= 1'b0;
    wr(IDX_EVT_EN, 8'h04);
    lat <= 8'h02;
    apb(1'b1, 12'h814, 32'h1234);
    chk({se, txn_write, txn_nonblocking, txn_byte, txn_addr, txn_wdata}, 28'h4051234,
      "blk wr");
    apb(1'b0, 12'h818, 32'h0);
    chk({16'h0, rd[15:0]}, 32'hc306, "blk rd");
    rchk(IDX_LAST_ADDR, 8'h06);
    rchk(IDX_DATA_HI, 8'hc3);
    apb(1'b1, 12'hc20, 32'h00ab);
    chk({se, txn_nonblocking, txn_addr}, 10'h108, "nb wr");
    rchk(IDX_LAST_ATTR, 8'h10);
    apb(1'b0, 12'h400, 32'h0);
    chk(se, 1'b1, "unmapped");
    chk(irq, 1'b1, "irq set");
    wr(IDX_EVT_CLR, 8'h04);
    chk(irq, 1'b0, "irq cleared");
    lat <= 8'h00;
    apb(1'b1, 12'h800, 32'h0);
    rchk(IDX_ERR_STAT, 8'h00);
    lat <= 8'd60;
    apb(1'b1, 12'h800, 32'h0);
    rchk(IDX_ERR_STAT, 8'h90);
    chk(error_irq_out, 1'b1, "error irq");
    wr(IDX_ERR_STAT, 8'h00);
    rchk(IDX_ERR_STAT, 8'h90);
    wr(IDX_ERR_STAT, 8'h80);
    rchk(IDX_ERR_STAT, 8'h00);
    evt_loop();
    // reset in mid-run reopens the write-once fields
    @(posedge pclk);
    presetn <= 1'b0;
    special_mode <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(IDX_CTRL_PRI, 8'h00);
    wr(IDX_CTRL_PRI, 8'h82);
    rchk(IDX_CTRL_PRI, 8'h82);
    end_sim();
  end
endmodule
